/* design/life_counter.sv */
// Percent life counter, counting down from full on each step
`timescale 1ns/100ps
module life_counter
    import life_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Step in, value out
    life_if.counter   lif
);
    // Saturates at zero so a worn part never wraps back to new
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lif.pct <= LIFE_FULL;
        end else if (lif.step && lif.pct != LIFE_ZERO) begin
            lif.pct <= lif.pct - 7'h01;
        end
    end
endmodule // life_counter

/* design/part_life_alarm_monitor.sv */
// Part wear supervision, life alarm and main capacitor measurement
`timescale 1ns/100ps
module part_life_alarm_monitor
    import life_pkg::*;
#(
    parameter int unsigned DC_CYCLES = DC_APPLY_CYC
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // Register port
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       wr_strobe,
    input  wire logic       rd_strobe,
    output logic      [7:0] rd_data,
    // Pins from the power stage
    input  wire logic       supply_on_pin,
    input  wire logic       motor_connected_pin,
    input  wire logic       motor_running_pin,
    input  wire logic       start_cmd_pin,
    input  wire logic       output_shutoff_input,
    input  wire logic       alarm_active_pin,
    input  wire logic       inrush_contact_pin,
    input  wire logic       fan_multi_pin,
    // Estimators on this clock
    input  wire logic       ctrl_cap_wear_step,
    input  wire logic [6:0] fan_speed_a,
    input  wire logic [6:0] fan_speed_b,
    input  wire logic [6:0] cap_meas_pct,
    // Outputs
    output logic            life_alarm_out,
    output logic [TERM_N-1:0] term_out,
    output logic            fan_fault_indication,
    output logic            dc_inject_out
);
    logic [7:0]  pins_s;
    logic        supply_s;
    logic        motor_con_s;
    logic        motor_run_s;
    logic        start_s;
    logic        shutoff_s;
    logic        alarm_s;
    logic        contact_s;
    logic        fan_multi_s;
    logic        supply_d_reg;
    logic        contact_d_reg;
    logic        supply_fall;
    logic        contact_rise;
    logic [13:0] inrush_cnt_reg;
    logic [6:0]  main_cap_reg;
    logic [3:0]  part_wear_status_reg;
    logic [3:0]  wear_next;
    logic        fan_fault_next;
    logic [7:0]  term_sel_reg [TERM_N];
    logic [25:0] dc_cnt_reg;
    logic [3:0]  meas_code;
    logic [7:0]  rd_next;
    logic        meas_wr;
    measure_e    state_reg;
    measure_e    state_next;

    life_if inrush_lif ();
    life_if ctrl_lif ();

    sync_bank #(.W(8)) u_sync (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .d       ({fan_multi_pin, inrush_contact_pin, alarm_active_pin,
                   output_shutoff_input, start_cmd_pin, motor_running_pin,
                   motor_connected_pin, supply_on_pin}),
        .q       (pins_s)
    );

    assign supply_s    = pins_s[0];
    assign motor_con_s = pins_s[1];
    assign motor_run_s = pins_s[2];
    assign start_s     = pins_s[3];
    assign shutoff_s   = pins_s[4];
    assign alarm_s     = pins_s[5];
    assign contact_s   = pins_s[6];
    assign fan_multi_s = pins_s[7];

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            supply_d_reg  <= 1'b0;
            contact_d_reg <= 1'b0;
        end else begin
            supply_d_reg  <= supply_s;
            contact_d_reg <= contact_s;
        end
    end

    assign supply_fall  = supply_d_reg && !supply_s;
    assign contact_rise = contact_s && !contact_d_reg;

    // Supply loss is only an input here; reset_n is the cold start alone
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            inrush_cnt_reg <= INRUSH_CNT_RST;
        end else if (contact_rise) begin
            if (inrush_cnt_reg == INRUSH_PER_PCT - 14'h0001) begin
                inrush_cnt_reg <= INRUSH_CNT_RST;
            end else begin
                inrush_cnt_reg <= inrush_cnt_reg + 14'h0001;
            end
        end
    end

    assign inrush_lif.step = contact_rise &&
        (inrush_cnt_reg == INRUSH_PER_PCT - 14'h0001);
    assign ctrl_lif.step = ctrl_cap_wear_step && supply_s;

    life_counter u_inrush (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .lif     (inrush_lif)
    );

    life_counter u_ctrl (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .lif     (ctrl_lif)
    );

    // Fan checks use the stricter figure once a second fan is fitted
    always_comb begin
        if (fan_multi_s) begin
            fan_fault_next = (fan_speed_a <= FAN_MULTI_PCT) ||
                             (fan_speed_b <= FAN_MULTI_PCT);
        end else begin
            fan_fault_next = fan_speed_a <= FAN_ONE_PCT;
        end
    end

    always_comb begin
        wear_next             = WEAR_RST;
        wear_next[BIT_INRUSH] = inrush_lif.pct <= INRUSH_ALM_PCT;
        wear_next[BIT_CTRL]   = ctrl_lif.pct < CTRL_ALM_PCT;
        wear_next[BIT_MAIN]   = main_cap_reg <= MAIN_ALM_PCT;
        wear_next[BIT_FAN]    = fan_fault_next;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            part_wear_status_reg <= WEAR_RST;
            life_alarm_out       <= 1'b0;
            fan_fault_indication <= 1'b0;
        end else begin
            part_wear_status_reg <= wear_next;
            life_alarm_out       <= |wear_next;
            fan_fault_indication <= fan_fault_next;
        end
    end

    // Terminals follow the registered alarm, one cycle behind it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            term_out <= '0;
        end else begin
            for (int i = 0; i < TERM_N; i++) begin
                if (term_sel_reg[i] == TERM_LIFE_SRC) begin
                    term_out[i] <= life_alarm_out;
                end else if (term_sel_reg[i] == TERM_LIFE_SNK) begin
                    term_out[i] <= !life_alarm_out;
                end else begin
                    term_out[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < TERM_N; i++) begin
                term_sel_reg[i] <= TERM_RST;
            end
        end else if (wr_strobe) begin
            if (addr == ADDR_TERM0) begin
                term_sel_reg[0] <= wr_data;
            end
            if (addr == ADDR_TERM1) begin
                term_sel_reg[1] <= wr_data;
            end
            if (addr == ADDR_TERM2) begin
                term_sel_reg[2] <= wr_data;
            end
        end
    end

    // Measurement register writes are refused while DC is on the motor
    assign meas_wr = wr_strobe && addr == ADDR_MEAS && state_reg != ST_DC;

    always_comb begin
        state_next = state_reg;
        if (meas_wr && wr_data == {4'h0, MS_IDLE}) begin
            state_next = ST_IDLE;
        end else if (meas_wr && wr_data == {4'h0, MS_START}) begin
            state_next = ST_START;
        end
        case (state_reg)
            ST_START: begin
                if (supply_fall) begin
                    if (alarm_s) begin
                        state_next = ST_START;
                    end else if (!motor_con_s || motor_run_s) begin
                        state_next = ST_ERROR;
                    end else if (shutoff_s) begin
                        state_next = ST_FORCED;
                    end else begin
                        state_next = ST_DC;
                    end
                end
            end
            ST_DC: begin
                if (start_s || shutoff_s || alarm_s) begin
                    state_next = ST_FORCED;
                end else if (!motor_con_s || motor_run_s) begin
                    state_next = ST_ERROR;
                end else if (supply_s) begin
                    state_next = ST_STUCK;
                end else if (dc_cnt_reg == DC_CNT_ZERO) begin
                    state_next = ST_DONE;
                end
            end
            ST_IDLE, ST_STUCK, ST_DONE, ST_FORCED, ST_ERROR: begin
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            dc_cnt_reg    <= DC_CNT_ZERO;
            dc_inject_out <= 1'b0;
        end else begin
            dc_inject_out <= state_next == ST_DC;
            if (state_reg != ST_DC) begin
                dc_cnt_reg <= 26'(DC_CYCLES - 1);
            end else if (dc_cnt_reg != DC_CNT_ZERO) begin
                dc_cnt_reg <= dc_cnt_reg - 26'h0000001;
            end
        end
    end

    // Front-end result above full scale is clamped to full
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            main_cap_reg <= LIFE_FULL;
        end else if (state_reg == ST_DC && state_next == ST_DONE) begin
            if (cap_meas_pct > LIFE_FULL) begin
                main_cap_reg <= LIFE_FULL;
            end else begin
                main_cap_reg <= cap_meas_pct;
            end
        end
    end

    always_comb begin
        case (state_reg)
            ST_IDLE:   meas_code = MS_IDLE;
            ST_START:  meas_code = MS_START;
            ST_DC:     meas_code = MS_MEAS;
            ST_STUCK:  meas_code = MS_MEAS;
            ST_DONE:   meas_code = MS_DONE;
            ST_FORCED: meas_code = MS_FORCED;
            ST_ERROR:  meas_code = MS_ERROR;
            default:   meas_code = MS_IDLE;
        endcase
    end

    // Indicator addresses have no write path at all
    always_comb begin
        case (addr)
            ADDR_WEAR:   rd_next = {4'h0, part_wear_status_reg};
            ADDR_INRUSH: rd_next = {1'b0, inrush_lif.pct};
            ADDR_CTRL:   rd_next = {1'b0, ctrl_lif.pct};
            ADDR_MAIN:   rd_next = {1'b0, main_cap_reg};
            ADDR_MEAS:   rd_next = {4'h0, meas_code};
            ADDR_TERM0:  rd_next = term_sel_reg[0];
            ADDR_TERM1:  rd_next = term_sel_reg[1];
            ADDR_TERM2:  rd_next = term_sel_reg[2];
            default:     rd_next = RD_ZERO;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= RD_ZERO;
        end else begin
            rd_data <= rd_strobe ? rd_next : RD_ZERO;
        end
    end

    a_alarm_any: assert property (@(posedge sys_clk) disable iff (!reset_n)
        life_alarm_out == (|part_wear_status_reg))
        else $error("life alarm disagrees with wear word");

    a_inrush_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        inrush_lif.pct <= INRUSH_ALM_PCT |=> part_wear_status_reg[3])
        else $error("inrush wear bit missing");

    a_ctrl_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        ctrl_lif.pct >= CTRL_ALM_PCT |=> !part_wear_status_reg[0])
        else $error("control capacitor bit set too early");

    a_main_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $changed(main_cap_reg) |=> part_wear_status_reg[BIT_MAIN] ==
        ($past(main_cap_reg) <= MAIN_ALM_PCT))
        else $error("main capacitor bit wrong after measurement");

    a_fan_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
        fan_fault_indication == part_wear_status_reg[2])
        else $error("fan fault and wear bit differ");

    a_term_source: assert property (@(posedge sys_clk) disable iff (!reset_n)
        term_sel_reg[0] == TERM_LIFE_SRC |=>
        term_out[0] == $past(life_alarm_out))
        else $error("terminal does not follow alarm");

    a_dc_begin: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(dc_inject_out) |-> $past(state_reg == ST_START) &&
        !$past(supply_s))
        else $error("DC applied without start and supply off");

    a_dc_done: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_reg == ST_DC ##1 state_reg == ST_DONE |->
        $past(dc_cnt_reg) == DC_CNT_ZERO && !dc_inject_out)
        else $error("measurement finished before DC time");

    a_ro_codes: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_reg == ST_IDLE && wr_strobe && addr == ADDR_MEAS &&
        wr_data == {4'h0, MS_DONE} |=> state_reg == ST_IDLE)
        else $error("read-only state code was accepted");

    a_stuck_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
        state_reg == ST_STUCK && !wr_strobe |=> state_reg == ST_STUCK)
        else $error("stuck measurement left on its own");
endmodule // part_life_alarm_monitor

/* design/sync_bank.sv */
// Two-stage synchroniser for a group of pin levels
`timescale 1ns/100ps
module sync_bank #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         sys_clk,
    input  wire logic         reset_n,
    // Levels
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // sync_bank

/* pkg/life_if.sv */
// Step and value link between the monitor and one life counter
`timescale 1ns/100ps
interface life_if;
    logic       step;
    logic [6:0] pct;
    modport counter (input step, output pct);
    modport user    (output step, input pct);
endinterface

/* pkg/life_pkg.sv */
// Constants, types and register map of the part life alarm monitor
package life_pkg;
    // Life indicator scale, in whole percent
    localparam logic [6:0]  LIFE_FULL      = 7'h64;
    localparam logic [6:0]  LIFE_ZERO      = 7'h00;
    localparam logic [6:0]  INRUSH_ALM_PCT = 7'h0a;
    localparam logic [6:0]  CTRL_ALM_PCT   = 7'h0a;
    localparam logic [6:0]  MAIN_ALM_PCT   = 7'h55;
    localparam logic [6:0]  FAN_ONE_PCT    = 7'h28;
    localparam logic [6:0]  FAN_MULTI_PCT  = 7'h32;
    // Contact closings per percent of inrush life
    localparam logic [13:0] INRUSH_PER_PCT = 14'h2710;
    localparam logic [13:0] INRUSH_CNT_RST = 14'h0000;
    // Bit positions of the wear status word
    localparam int          BIT_CTRL       = 0;
    localparam int          BIT_MAIN       = 1;
    localparam int          BIT_FAN        = 2;
    localparam int          BIT_INRUSH     = 3;
    localparam logic [3:0]  WEAR_RST       = 4'h0;
    // Measurement state codes
    localparam logic [3:0]  MS_IDLE        = 4'h0;
    localparam logic [3:0]  MS_START       = 4'h1;
    localparam logic [3:0]  MS_MEAS        = 4'h2;
    localparam logic [3:0]  MS_DONE        = 4'h3;
    localparam logic [3:0]  MS_FORCED      = 4'h8;
    localparam logic [3:0]  MS_ERROR       = 4'h9;
    // Output terminal function codes
    localparam logic [7:0]  TERM_LIFE_SRC  = 8'h5a;
    localparam logic [7:0]  TERM_LIFE_SNK  = 8'hbe;
    localparam logic [7:0]  TERM_RST       = 8'h00;
    localparam int          TERM_N         = 3;
    // Register word addresses
    localparam logic [3:0]  ADDR_WEAR      = 4'h0;
    localparam logic [3:0]  ADDR_INRUSH    = 4'h1;
    localparam logic [3:0]  ADDR_CTRL      = 4'h2;
    localparam logic [3:0]  ADDR_MAIN      = 4'h3;
    localparam logic [3:0]  ADDR_MEAS      = 4'h4;
    localparam logic [3:0]  ADDR_TERM0     = 4'h5;
    localparam logic [3:0]  ADDR_TERM1     = 4'h6;
    localparam logic [3:0]  ADDR_TERM2     = 4'h7;
    localparam logic [7:0]  RD_ZERO        = 8'h00;
    // DC injection time at power-off
    localparam int unsigned DC_APPLY_MS    = 1000;
    localparam int unsigned CLK_KHZ        = 40000;
    localparam int unsigned DC_APPLY_CYC   = DC_APPLY_MS * CLK_KHZ;
    localparam logic [25:0] DC_CNT_ZERO    = 26'h0000000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_START, ST_DC, ST_STUCK, ST_DONE, ST_FORCED, ST_ERROR
    } measure_e;
endpackage

/* verification/panel_model.sv */
// Operator panel model: register master and supply switch
`timescale 1ns/100ps
module panel_model
    import life_pkg::*;
(
    // Clock
    input  wire logic       sys_clk,
    // Register port
    output logic      [3:0] addr,
    output logic      [7:0] wr_data,
    output logic            wr_strobe,
    output logic            rd_strobe,
    input  wire logic [7:0] rd_data,
    // Supply and DC monitor
    output logic            supply_on_pin,
    input  wire logic       dc_inject_out
);
    initial begin
        addr = 4'h0;
        wr_data = 8'h00;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
        supply_on_pin = 1'b1;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr      <= a;
        wr_data   <= d;
        wr_strobe <= 1'b1;
        @(posedge sys_clk);
        wr_strobe <= 1'b0;
        wr_data   <= ~d;   // Released bus shows no stale value
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr      <= a;
        rd_strobe <= 1'b1;
        @(posedge sys_clk);
        rd_strobe <= 1'b0;
        #1 d = rd_data;
    endtask
    // Cool-down wait cut to nothing, too long for simulation
    task automatic measure(input int hold, output logic dc_mid);
        wr(ADDR_MEAS, {4'h0, MS_START});
        @(posedge sys_clk);
        supply_on_pin <= 1'b0;
        dc_mid = 1'b0;
        for (int i = 0; i < hold; i++) begin
            @(posedge sys_clk);
            if (i == 8) dc_mid = dc_inject_out;
        end
        supply_on_pin <= 1'b1;
        repeat (6) @(posedge sys_clk);
    endtask
endmodule // panel_model

/* verification/part_life_alarm_monitor_bench.sv */
// Self-checking bench of the part life alarm monitor
`timescale 1ns/100ps
module part_life_alarm_monitor_bench
    import life_pkg::*;
;
    logic        sys_clk, reset_n, wr_strobe, rd_strobe, supply_on_pin;
    logic [3:0]  addr;
    logic [7:0]  wr_data, rd_data, rv;
    logic        motor_connected_pin, motor_running_pin, start_cmd_pin;
    logic        output_shutoff_input, alarm_active_pin, dc_inject_out;
    logic        inrush_contact_pin, fan_multi_pin, ctrl_cap_wear_step;
    logic [6:0]  fan_speed_a, fan_speed_b, cap_meas_pct, ctrl, main, inr;
    logic        life_alarm_out, fan_fault_indication;
    logic [2:0]  term_out;
    logic [7:0]  sel [3];
    logic [31:0] rng;
    int          fails, samples_checked;

    part_life_alarm_monitor #(.DC_CYCLES(20)) i_part_life_alarm_monitor (
        .sys_clk, .reset_n, .addr, .wr_data, .wr_strobe, .rd_strobe,
        .rd_data, .supply_on_pin, .motor_connected_pin,
        .motor_running_pin, .start_cmd_pin, .output_shutoff_input,
        .alarm_active_pin, .inrush_contact_pin, .fan_multi_pin,
        .ctrl_cap_wear_step, .fan_speed_a, .fan_speed_b, .cap_meas_pct,
        .life_alarm_out, .term_out, .fan_fault_indication, .dc_inject_out
    );
    panel_model i_panel_model (
        .sys_clk, .addr, .wr_data, .wr_strobe, .rd_strobe, .rd_data,
        .supply_on_pin, .dc_inject_out
    );

    function automatic logic [7:0] xs(input int lim);
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return 8'(rng % lim);
    endfunction
    function automatic logic fan_exp();
        return fan_multi_pin ? (fan_speed_a <= FAN_MULTI_PCT ||
            fan_speed_b <= FAN_MULTI_PCT) : fan_speed_a <= FAN_ONE_PCT;
    endfunction
    function automatic logic [3:0] wear_exp();
        return {inr <= INRUSH_ALM_PCT, fan_exp(), main <= MAIN_ALM_PCT,
                ctrl < CTRL_ALM_PCT};
    endfunction
    task automatic chk(input string n, input logic [7:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rdc(input string n, input logic [3:0] a,
                       input logic [7:0] e);
        i_panel_model.rd(a, rv);
        chk(n, rv, e);
    endtask
    task automatic check_all();
        logic [3:0] w;
        logic [2:0] t;
        w = wear_exp();
        for (int i = 0; i < TERM_N; i++)
            t[i] = sel[i] == TERM_LIFE_SRC ? |w
                 : sel[i] == TERM_LIFE_SNK ? ~|w : 1'b0;
        rdc("wear", ADDR_WEAR, {4'h0, w});
        chk("alarm", {7'h0, life_alarm_out}, {7'h0, |w});
        chk("term", {5'h0, term_out}, {5'h0, t});
    endtask
    task automatic meas(input logic [4:0] c, input int hold,
                        input logic [3:0] code);
        logic dm;
        output_shutoff_input <= c[0];
        motor_connected_pin  <= ~c[1];
        motor_running_pin    <= c[2];
        alarm_active_pin     <= c[3];
        start_cmd_pin        <= c[4];
        cap_meas_pct         <= 7'(xs(51) + 8'd60);
        i_panel_model.measure(hold, dm);
        {output_shutoff_input, motor_running_pin} <= 2'b00;
        {alarm_active_pin, start_cmd_pin} <= 2'b00;
        motor_connected_pin <= 1'b1;
        if (code == MS_DONE)
            main = cap_meas_pct > LIFE_FULL ? LIFE_FULL : cap_meas_pct;
        rdc("state", ADDR_MEAS, {4'h0, code});
        if (c == 5'h00) chk("dc", {7'h0, dm}, 8'h01);
        chk("dc off", {7'h0, dc_inject_out}, 8'h00);
        rdc("main", ADDR_MAIN, {1'b0, main});
        check_all();
        $display("test measure code %0d done", code);
    endtask
    task automatic step_ctrl(input int n);
        repeat (n) begin
            @(posedge sys_clk) ctrl_cap_wear_step <= 1'b1;
            @(posedge sys_clk) ctrl_cap_wear_step <= 1'b0;
        end
        ctrl = ctrl - 7'(n);
    endtask
    task automatic close_contacts(input int n);
        repeat (n) begin
            repeat (2) @(posedge sys_clk);
            inrush_contact_pin <= 1'b1;
            repeat (2) @(posedge sys_clk);
            inrush_contact_pin <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Run needs about 41000 cycles
    initial begin
        #2250000;
        fails++;
        test_done();
    end
    initial begin
        rng = 32'h2d8d6b4a;
        fails = 0;
        samples_checked = 0;
        reset_n = 1'b0;
        {motor_running_pin, start_cmd_pin, output_shutoff_input} = 3'b000;
        {alarm_active_pin, inrush_contact_pin, fan_multi_pin} = 3'b000;
        motor_connected_pin = 1'b1;
        ctrl_cap_wear_step = 1'b0;
        {fan_speed_a, fan_speed_b, cap_meas_pct} = {3{LIFE_FULL}};
        {ctrl, main, inr} = {3{LIFE_FULL}};
        sel = '{default: TERM_RST};
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Read-only places keep their value against random writes
        for (int a = 0; a < 16; a++)
            if (a < 4 || a > 7) i_panel_model.wr(a[3:0], xs(256));
        for (int a = 0; a < 9; a++)
            rdc("reset", a[3:0], (a > 0 && a < 4) ? 8'h64 : 8'h00);
        // Report-only state codes are refused
        i_panel_model.wr(ADDR_MEAS, 8'h02);
        i_panel_model.wr(ADDR_MEAS, 8'h03);
        i_panel_model.wr(ADDR_MEAS, 8'h09);
        rdc("state", ADDR_MEAS, 8'h00);
        i_panel_model.wr(ADDR_MEAS, 8'h01);
        rdc("state", ADDR_MEAS, 8'h01);
        i_panel_model.wr(ADDR_MEAS, 8'h00);
        rdc("state", ADDR_MEAS, 8'h00);
        sel = '{TERM_LIFE_SRC, TERM_LIFE_SNK, 8'h5b};
        for (int i = 0; i < TERM_N; i++)
            i_panel_model.wr(ADDR_TERM0 + 4'(i), sel[i]);
        rdc("sel", ADDR_TERM1, TERM_LIFE_SNK);
        check_all();
        $display("test registers done");
        // Boundary: 10 holds, 9 raises the alarm
        step_ctrl(90);
        rdc("ctrl", ADDR_CTRL, 8'h0a);
        check_all();
        step_ctrl(1);
        rdc("ctrl", ADDR_CTRL, 8'h09);
        check_all();
        $display("test control capacitor done");
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            fan_multi_pin <= i[0];
            fan_speed_a <= i < 4 ? (i[0] ? FAN_MULTI_PCT : FAN_ONE_PCT)
                                   + 7'(i[1]) : 7'(xs(101));
            fan_speed_b <= i < 4 ? LIFE_FULL : 7'(xs(101));
            repeat (4) @(posedge sys_clk);
            chk("fan", {7'h0, fan_fault_indication},
                {7'h0, fan_exp()});
            check_all();
        end
        {fan_speed_a, fan_speed_b} <= {2{LIFE_FULL}};
        fan_multi_pin <= 1'b0;
        $display("test fan done");
        meas(5'h00, 40, MS_DONE);
        meas(5'h01, 40, MS_FORCED);
        meas(5'h02, 40, MS_ERROR);
        meas(5'h04, 40, MS_ERROR);
        meas(5'h08, 40, MS_START);
        meas(5'h10, 40, MS_FORCED);
        meas(5'h00, 10, MS_MEAS);
        meas(5'h00, 40, MS_DONE);
        rdc("ctrl", ADDR_CTRL, 8'h09);
        close_contacts(9999);
        rdc("inrush", ADDR_INRUSH, 8'h64);
        close_contacts(1);
        inr = 7'h63;
        rdc("inrush", ADDR_INRUSH, 8'h63);
        check_all();
        $display("test inrush done");
        test_done();
    end
endmodule // part_life_alarm_monitor_bench
